// ===== state_sensor_init_handler.v
/*
 * State sensor setup command engine with an APB register front end.
 * Software loads a handle, a sub-sensor count and up to eight init
 * entries, then starts the command; the engine validates the whole
 * request, applies it and posts a result code and an interrupt.
 * Assumes an APB master on pclk; all inputs are in the pclk domain.
 */
// Overview of operation
// - The 16-bit handle values 0x0000 and 0xFFFF never name a sensor.
// - Entries map in order to sub-sensor offsets 0 to 7 of the addressed sensor.
// - The result is 0x80 for an unknown handle and 0x81 for an illegal state or condition.
// - Each sub-sensor gets its state and event setting before its condition.
// - The condition is one of enabled, disabled or unavailable.
// - The event field turns reporting on or off, and 0xFF keeps the setting.
// - Only states from the allowed subset of the state set are accepted.
// - Each entry is condition, state and event control, in that order.
// - Every actuator handle is unique among the actuators of this block.
`timescale 1ns/1ps
`include "state_sensor_defines.vh"

module state_sensor_init_handler (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    output wire irq,
    output reg [15:0] sensor_event_en,
    output reg [15:0] sensor_enabled,
    output reg [63:0] actuator_state
);
    // ============================================================
    // Engine states
    localparam S_IDLE = 3'h0;
    localparam S_CHECK = 3'h1;
    localparam S_APPLY_SE = 3'h2;
    localparam S_APPLY_OP = 3'h3;
    localparam S_DONE = 3'h4;

    // ============================================================
    // Decode helpers
    function addr_known;
        input [7:0] a;
        begin
            addr_known = (a == `OFF_CTRL) || (a == `OFF_HANDLE) ||
                         (a == `OFF_COUNT) || (a == `OFF_STATUS) ||
                         (a == `OFF_ALLOW) || (a == `OFF_VIEW_SEL) ||
                         (a == `OFF_VIEW) || (a == `OFF_IRQ_STAT) ||
                         (a == `OFF_IRQ_MASK) ||
                         ((a >= `OFF_ENTRY_BASE) && (a <= `OFF_ENTRY_LAST) &&
                          (a[1:0] == 2'b00));
        end
    endfunction

    function is_entry;
        input [7:0] a;
        begin
            is_entry = (a >= `OFF_ENTRY_BASE) && (a <= `OFF_ENTRY_LAST);
        end
    endfunction

    // Flat index of sub-sensor within the sensor table.
    function [3:0] flat_index;
        input sensor_sel;
        input [2:0] offset;
        begin
            flat_index = {sensor_sel, offset};
        end
    endfunction

    // ============================================================
    // Request and configuration registers
    reg [15:0] handle_reg;
    reg [7:0] count_reg;
    reg kind_reg;
    reg [7:0] allow_reg;
    reg [3:0] view_sel_reg;
    reg [23:0] entry_reg [0:7];
    reg [7:0] result_reg;
    reg [2:0] state_reg;
    reg [2:0] idx_reg;
    reg sensor_sel_reg;
    reg [1:0] event_pulse;

    // Sensor table, two composite sensors of eight sub-sensors.
    reg [7:0] cond_mem [0:15];
    reg [7:0] value_mem [0:15];
    reg evt_mem [0:15];
    reg [7:0] act_mem [0:7];

    wire [1:0] irq_stat;
    wire [1:0] irq_mask;
    wire [7:0] entry_code;
    wire busy;
    wire setup_phase;
    wire wr_access;
    wire [23:0] cur_entry;
    wire [7:0] cur_cond;
    wire [7:0] cur_value;
    wire [7:0] cur_evt;
    wire [3:0] cur_flat;
    wire [7:0] last_idx;
    integer i;
    integer j;
    integer k;

    assign busy = (state_reg != S_IDLE);
    assign setup_phase = psel && !penable;
    // A write to an unmapped address is dropped, as its error flag is already up.
    assign wr_access = psel && penable && pwrite && !pslverr;
    // Every access finishes in its first access cycle, so there are no wait states.
    assign pready = 1'b1;
    assign cur_entry = entry_reg[idx_reg];
    assign cur_cond = cur_entry[`ENTRY_OP_LSB +: 8];
    assign cur_value = cur_entry[`ENTRY_STATE_LSB +: 8];
    assign cur_evt = cur_entry[`ENTRY_EVT_LSB +: 8];
    assign cur_flat = flat_index(sensor_sel_reg, idx_reg);
    assign last_idx = count_reg - `COUNT_MIN;

    entry_checker u_check (
        .kind_actuator(kind_reg),
        .allow_mask(allow_reg),
        .operating_condition(cur_cond),
        .initial_state_value(cur_value),
        .event_report_control(cur_evt),
        .entry_code(entry_code)
    );

    // Status bits are set by the engine's done pulse and cleared by software.
    irq_status u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .event_set(event_pulse),
        .stat_wr(wr_access && (paddr == `OFF_IRQ_STAT)),
        .mask_wr(wr_access && (paddr == `OFF_IRQ_MASK)),
        .wdata(pwdata[1:0]),
        .stat_reg(irq_stat),
        .mask_reg(irq_mask),
        .irq(irq)
    );

    // ============================================================
    // APB read data and error, captured in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `ZERO32;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            pslverr <= !addr_known(paddr);
            prdata <= `ZERO32;
            // A misaligned entry address reads as zero, like any unmapped offset.
            if (is_entry(paddr) && addr_known(paddr)) begin
                prdata <= {8'h00, entry_reg[paddr[4:2]]};
            end else begin
                case (paddr)
                    `OFF_CTRL: prdata <= {30'd0, kind_reg, 1'b0};
                    `OFF_HANDLE: prdata <= {16'h0000, handle_reg};
                    `OFF_COUNT: prdata <= {24'h000000, count_reg};
                    `OFF_STATUS: prdata <= {16'h0000, result_reg, 7'd0, busy};
                    `OFF_ALLOW: prdata <= {24'h000000, allow_reg};
                    `OFF_VIEW_SEL: prdata <= {28'h0000000, view_sel_reg};
                    `OFF_VIEW: prdata <= {15'd0, evt_mem[view_sel_reg],
                                          value_mem[view_sel_reg],
                                          cond_mem[view_sel_reg]};
                    `OFF_IRQ_STAT: prdata <= {30'd0, irq_stat};
                    `OFF_IRQ_MASK: prdata <= {30'd0, irq_mask};
                    default: prdata <= `ZERO32;
                endcase
            end
        end
    end

    // ============================================================
    // Software-written registers; request fields are frozen while busy
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            handle_reg <= `ZERO16;
            count_reg <= `ZERO8;
            kind_reg <= 1'b0;
            allow_reg <= `ALLOW_RESET;
            view_sel_reg <= 4'h0;
            for (i = 0; i < 8; i = i + 1) begin
                entry_reg[i] <= 24'h000000;
            end
        end else if (wr_access) begin
            if (paddr == `OFF_VIEW_SEL) begin
                view_sel_reg <= pwdata[3:0];
            end
            if (!busy) begin
                if (paddr == `OFF_HANDLE) begin
                    handle_reg <= pwdata[15:0];
                end
                if (paddr == `OFF_COUNT) begin
                    count_reg <= pwdata[7:0];
                end
                if (paddr == `OFF_ALLOW) begin
                    allow_reg <= pwdata[7:0];
                end
                if (paddr == `OFF_CTRL) begin
                    kind_reg <= pwdata[`CTRL_KIND_BIT];
                end
                if (is_entry(paddr)) begin
                    entry_reg[paddr[4:2]] <= pwdata[23:0];
                end
            end
        end
    end

    // ============================================================
    // Command engine
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_IDLE;
            idx_reg <= 3'd0;
            sensor_sel_reg <= 1'b0;
            result_reg <= `CODE_SUCCESS;
            event_pulse <= 2'b00;
            for (j = 0; j < 16; j = j + 1) begin
                cond_mem[j] <= `COND_RESET;
                value_mem[j] <= `ZERO8;
                evt_mem[j] <= 1'b0;
            end
            for (j = 0; j < 8; j = j + 1) begin
                act_mem[j] <= `ZERO8;
            end
        end else begin
            event_pulse <= 2'b00;
            case (state_reg)
                S_IDLE: begin
                    idx_reg <= 3'd0;
                    if (wr_access && (paddr == `OFF_CTRL) && pwdata[`CTRL_GO_BIT]) begin
                        state_reg <= S_CHECK;
                        // The handle picks the composite sensor; the checks below may reject it.
                        sensor_sel_reg <= (handle_reg == `SENSOR1_HANDLE);
                        if ((handle_reg == `HANDLE_RSVD_LO) ||
                            (handle_reg == `HANDLE_RSVD_HI)) begin
                            result_reg <= `BAD_HANDLE_CODE;
                            state_reg <= S_DONE;
                        end else if (pwdata[`CTRL_KIND_BIT] &&
                                     (handle_reg != `ACTUATOR_HANDLE)) begin
                            result_reg <= `BAD_HANDLE_CODE;
                            state_reg <= S_DONE;
                        end else if (!pwdata[`CTRL_KIND_BIT] &&
                                     (handle_reg != `SENSOR0_HANDLE) &&
                                     (handle_reg != `SENSOR1_HANDLE)) begin
                            result_reg <= `BAD_HANDLE_CODE;
                            state_reg <= S_DONE;
                        end else if ((count_reg < `COUNT_MIN) ||
                                     (count_reg > `COUNT_MAX)) begin
                            result_reg <= `CODE_INVALID_DATA;
                            state_reg <= S_DONE;
                        end
                    end
                end
                S_CHECK: begin
                    if (entry_code != `CODE_SUCCESS) begin
                        result_reg <= entry_code;
                        state_reg <= S_DONE;
                    end else if ({5'd0, idx_reg} == last_idx) begin
                        idx_reg <= 3'd0;
                        state_reg <= S_APPLY_SE;
                    end else begin
                        idx_reg <= idx_reg + 3'd1;
                    end
                end
                S_APPLY_SE: begin
                    if (kind_reg) begin
                        act_mem[idx_reg] <= cur_value;
                        if ({5'd0, idx_reg} == last_idx) begin
                            result_reg <= `CODE_SUCCESS;
                            state_reg <= S_DONE;
                        end else begin
                            idx_reg <= idx_reg + 3'd1;
                        end
                    end else begin
                        value_mem[cur_flat] <= cur_value;
                        if (cur_evt != `KEEP_SETTING) begin
                            evt_mem[cur_flat] <= (cur_evt == `EVENTS_ON);
                        end
                        state_reg <= S_APPLY_OP;
                    end
                end
                S_APPLY_OP: begin
                    cond_mem[cur_flat] <= cur_cond;
                    if ({5'd0, idx_reg} == last_idx) begin
                        result_reg <= `CODE_SUCCESS;
                        state_reg <= S_DONE;
                    end else begin
                        idx_reg <= idx_reg + 3'd1;
                        state_reg <= S_APPLY_SE;
                    end
                end
                S_DONE: begin
                    event_pulse[`IRQ_DONE_BIT] <= 1'b1;
                    event_pulse[`IRQ_ERR_BIT] <= (result_reg != `CODE_SUCCESS);
                    state_reg <= S_IDLE;
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // Registered views of the sensor and actuator tables
    // Tables are copied whole every cycle, so each output bit follows its table entry one edge later.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sensor_event_en <= `ZERO16;
            sensor_enabled <= `ZERO16;
            actuator_state <= 64'h0000000000000000;
        end else begin
            for (k = 0; k < 16; k = k + 1) begin
                sensor_event_en[k] <= evt_mem[k];
                sensor_enabled[k] <= (cond_mem[k] == `COND_ENABLED);
            end
            for (k = 0; k < 8; k = k + 1) begin
                actuator_state[k*8 +: 8] <= act_mem[k];
            end
        end
    end
endmodule // state_sensor_init_handler

// ===== state_sensor_defines.vh
/*
 * Constants of the state sensor setup block: register offsets, field
 * positions, reset values, enumerations and result codes.
 * Assumes inclusion by bare name from every design file that needs it.
 */
`ifndef STATE_SENSOR_DEFINES_VH
`define STATE_SENSOR_DEFINES_VH

// ============================================================
// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_HANDLE 8'h04
`define OFF_COUNT 8'h08
`define OFF_STATUS 8'h0C
`define OFF_ALLOW 8'h10
`define OFF_VIEW_SEL 8'h14
`define OFF_VIEW 8'h18
`define OFF_IRQ_STAT 8'h1C
`define OFF_IRQ_MASK 8'h20
`define OFF_ENTRY_BASE 8'h40
`define OFF_ENTRY_LAST 8'h5C

// ============================================================
// Field positions
`define CTRL_GO_BIT 0
`define CTRL_KIND_BIT 1
`define ENTRY_OP_LSB 0
`define ENTRY_STATE_LSB 8
`define ENTRY_EVT_LSB 16
`define STATUS_CODE_LSB 8
`define IRQ_DONE_BIT 0
`define IRQ_ERR_BIT 1

// ============================================================
// Handles (values arbitrary) and reserved handles
`define HANDLE_RSVD_LO 16'h0000
`define HANDLE_RSVD_HI 16'hFFFF
`define SENSOR0_HANDLE 16'h0010
`define SENSOR1_HANDLE 16'h0011
`define ACTUATOR_HANDLE 16'h0020

// ============================================================
// Entry enumerations
`define COND_ENABLED 8'h00
`define COND_DISABLED 8'h01
`define COND_UNAVAILABLE 8'h02
`define EVENTS_OFF 8'h00
`define EVENTS_ON 8'h01
`define KEEP_SETTING 8'hFF
`define COUNT_MIN 8'h01
`define COUNT_MAX 8'h08
`define STATE_LIMIT 8'h08

// ============================================================
// Result codes
`define CODE_SUCCESS 8'h00
`define CODE_INVALID_DATA 8'h02
`define BAD_HANDLE_CODE 8'h80
`define BAD_STATE_CODE 8'h81

// ============================================================
// Reset values
`define ALLOW_RESET 8'hFF
`define COND_RESET 8'h02
`define ZERO8 8'h00
`define ZERO16 16'h0000
`define ZERO32 32'h00000000

`endif

// ===== entry_checker.v
/*
 * Combinational check of one init entry.
 * Assumes the caller holds the entry and the allowed-state mask steady.
 */
`timescale 1ns/1ps
`include "state_sensor_defines.vh"

module entry_checker (
    input wire kind_actuator,
    input wire [7:0] allow_mask,
    input wire [7:0] operating_condition,
    input wire [7:0] initial_state_value,
    input wire [7:0] event_report_control,
    output reg [7:0] entry_code
);
    reg cond_ok;
    reg state_ok;
    reg evt_ok;

    always @* begin
        cond_ok = (operating_condition == `COND_ENABLED) ||
                  (operating_condition == `COND_DISABLED) ||
                  (operating_condition == `COND_UNAVAILABLE);
        state_ok = (initial_state_value < `STATE_LIMIT) &&
                   allow_mask[initial_state_value[2:0]];
        evt_ok = (event_report_control == `EVENTS_ON) ||
                 (event_report_control == `EVENTS_OFF) ||
                 (event_report_control == `KEEP_SETTING);
        if (kind_actuator) begin
            entry_code = state_ok ? `CODE_SUCCESS : `BAD_STATE_CODE;
        end else if (!cond_ok || !state_ok) begin
            entry_code = `BAD_STATE_CODE;
        end else if (!evt_ok) begin
            entry_code = `CODE_INVALID_DATA;
        end else begin
            entry_code = `CODE_SUCCESS;
        end
    end
endmodule // entry_checker

// ===== irq_status.v
/*
 * Sticky interrupt status with write-one-to-clear, mask and level output.
 * Assumes write strobes are single-cycle pulses on pclk.
 */
`timescale 1ns/1ps
`include "state_sensor_defines.vh"

module irq_status (
    input wire pclk,
    input wire presetn,
    input wire [1:0] event_set,
    input wire stat_wr,
    input wire mask_wr,
    input wire [1:0] wdata,
    output reg [1:0] stat_reg,
    output reg [1:0] mask_reg,
    output wire irq
);
    reg [1:0] stat_next;

    always @* begin
        stat_next = stat_reg;
        if (stat_wr) begin
            stat_next = stat_next & ~wdata;
        end
        // A new event wins over a clear in the same cycle.
        stat_next = stat_next | event_set;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg <= 2'b00;
            mask_reg <= 2'b00;
        end else begin
            stat_reg <= stat_next;
            if (mask_wr) begin
                mask_reg <= wdata;
            end
        end
    end

    assign irq = |(stat_reg & mask_reg);
endmodule // irq_status

// ===== state_sensor_init_handler_chk.sv
/* Assertions on the ports of the state sensor setup block.
   Assumes the block's APB and table ports, one pclk domain. */
`timescale 1ns/1ps
`include "state_sensor_defines.vh"
module state_sensor_init_handler_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire irq,
    input wire [15:0] sensor_event_en,
    input wire [15:0] sensor_enabled,
    input wire [63:0] actuator_state
);
    // ==========
    // Helper state
    reg [5:0] since_go_reg;
    reg [15:0] handle_reg;
    reg [7:0] count_reg;
    wire acc_wr = psel && penable && pwrite;
    wire go = acc_wr && paddr == `OFF_CTRL && pwdata[`CTRL_GO_BIT] && since_go_reg > 6'd40;
    wire [31:0] tbl = {sensor_enabled, sensor_event_en};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_go_reg <= 6'h3F;
            handle_reg <= 16'h0001;
            count_reg <= 8'h01;
        end else begin
            if (acc_wr && paddr == `OFF_CTRL && pwdata[`CTRL_GO_BIT])
                since_go_reg <= 6'h00;
            else if (since_go_reg != 6'h3F)
                since_go_reg <= since_go_reg + 6'h01;
            if (acc_wr && paddr == `OFF_HANDLE)
                handle_reg <= pwdata[15:0];
            if (acc_wr && paddr == `OFF_COUNT)
                count_reg <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========
    // Properties
    reserved_keep_a: assert property (go && (handle_reg == 16'h0000 || handle_reg == 16'hFFFF)
        |=> ($stable(tbl) && $stable(actuator_state))[*8]) else $error("reserved handle changed");
    count_keep_a: assert property (go && (count_reg == 8'h00 || count_reg > 8'h08)
        |=> ($stable(tbl) && $stable(actuator_state))[*8]) else $error("bad count changed");
    quiet_idle_a: assert property (!$stable({tbl, actuator_state}) |-> since_go_reg <= 6'd40)
        else $error("table changed with no command");
    irq_cause_a: assert property ($rose(irq) |-> since_go_reg <= 6'd40 || $past(acc_wr))
        else $error("irq rose with no cause");
    irq_drop_a: assert property ($fell(irq) |-> $past(acc_wr))
        else $error("irq fell with no write");
    actuator_only_a: assert property (go && pwdata[`CTRL_KIND_BIT] |=> $stable(tbl)[*8])
        else $error("actuator command changed sensors");
    sensor_only_a: assert property (go && !pwdata[`CTRL_KIND_BIT]
        |=> $stable(actuator_state)[*8]) else $error("sensor command changed actuators");
    bad_actuator_a: assert property (go && pwdata[`CTRL_KIND_BIT]
        && handle_reg != `ACTUATOR_HANDLE |=> $stable(actuator_state)[*8])
        else $error("unknown actuator handle applied");
    go_cov: cover property (go ##[1:30] $rose(irq));
    clear_cov: cover property ($fell(irq));
    act_cov: cover property (!$stable(actuator_state));
endmodule // state_sensor_init_handler_chk

bind state_sensor_init_handler state_sensor_init_handler_chk i_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .sensor_event_en(sensor_event_en), .sensor_enabled(sensor_enabled),
    .actuator_state(actuator_state));

// ===== init_agent.sv
/* APB requester model standing for the initialization agent.
   Assumes a zero or more wait-state APB slave on pclk. */
`timescale 1ns/1ps
`include "state_sensor_defines.vh"
module init_agent (
    input wire pclk,
    input wire presetn,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
    end
    // One transfer; released data lines show the inverse of the last word.
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] q, output logic e);
        wait (presetn === 1'b1);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
    task put_entry(input logic [2:0] i, input logic [7:0] c, input logic [7:0] s,
                   input logic [7:0] v);
        logic [31:0] q;
        logic e;
        xfer(1'b1, `OFF_ENTRY_BASE + {3'h0, i, 2'h0}, {8'h00, v, s, c}, q, e);
    endtask
endmodule // init_agent

// ===== state_sensor_init_handler_test.sv
/* Self-checking bench for the state sensor setup block.
   Assumes the init_agent model and the bound checker. */
`timescale 1ns/1ps
`include "state_sensor_defines.vh"
module state_sensor_init_handler_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    wire psel, penable, pwrite, pready, pslverr, irq;
    wire [7:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [15:0] ev_en, en;
    wire [63:0] act;
    int err_total = 0;
    int compares = 0;
    logic [31:0] q;
    logic e;
    logic [7:0] code;
    logic [1:0] mask_v = 2'b00;
    logic [7:0] cond_t [3] = '{`COND_ENABLED, `COND_DISABLED, `COND_UNAVAILABLE};
    logic [7:0] ev_t [3] = '{`EVENTS_ON, `EVENTS_OFF, `KEEP_SETTING};
    logic [15:0] h_t [9] = '{16'h0000, 16'hFFFF, 16'h0012, 16'h0010, 16'h0010, 16'h0010,
                             16'h0010, 16'h0011, 16'h0010};
    logic [7:0] n_t [9] = '{8, 8, 8, 0, 9, 8, 8, 8, 8};
    logic [7:0] c_t [9] = '{0, 0, 0, 0, 0, 8'h03, 0, 0, 0};
    logic [7:0] s_t [9] = '{1, 1, 1, 1, 1, 1, 8, 5, 1};
    logic [7:0] v_t [9] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h02};
    logic [7:0] x_t [9] = '{8'h80, 8'h80, 8'h80, 8'h02, 8'h02, 8'h81, 8'h81, 8'h81, 8'h02};
    always #2 pclk = ~pclk;
    state_sensor_init_handler i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .sensor_event_en(ev_en),
        .sensor_enabled(en), .actuator_state(act));
    init_agent i_agent (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    task chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task rd(input logic [7:0] a);
        i_agent.xfer(1'b0, a, 32'h00000000, q, e);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        i_agent.xfer(1'b1, a, d, q, e);
    endtask
    // Starts a command, polls until idle, checks and clears the interrupt.
    task run(input logic kind, input logic [15:0] h, input logic [7:0] n,
             input logic [7:0] x);
        int k;
        wr(`OFF_COUNT, {24'h000000, n});
        wr(`OFF_HANDLE, {16'h0000, h});
        wr(`OFF_CTRL, {30'h00000000, kind, 1'b1});
        q = 32'h00000001;
        for (k = 0; k < 60 && q[0] !== 1'b0; k++) rd(`OFF_STATUS);
        chk(q[0], 1'b0);
        code = q[15:8];
        chk(code, x);
        rd(`OFF_IRQ_STAT);
        chk(q[1:0], {x != `CODE_SUCCESS, 1'b1});
        chk(irq, mask_v != 2'b00);
        wr(`OFF_IRQ_STAT, 32'h00000003);
        @(posedge pclk);
        chk(irq, 1'b0);
    endtask
    task end_of_test;
        $display("counts: %0d compares, %0d mismatches", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_of_test;
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(`OFF_ALLOW);
        chk(q, 32'h000000FF);
        rd(8'h30);
        chk({e, q}, {1'b1, 32'h0});
        rd(`OFF_VIEW);
        chk(q[7:0], `COND_RESET);
        $display("test reset done");
        for (int i = 0; i < 8; i++) i_agent.put_entry(i, cond_t[i % 3], i, ev_t[i % 3]);
        run(1'b0, `SENSOR0_HANDLE, 8'h08, `CODE_SUCCESS);
        chk(code, `CODE_SUCCESS);
        chk({ev_en, en}, 32'h00490049);
        for (int i = 0; i < 8; i++) begin
            wr(`OFF_VIEW_SEL, i);
            rd(`OFF_VIEW);
            chk(q[16:0], {i % 3 == 0, i[7:0], cond_t[i % 3]});
        end
        $display("test sensor_full done");
        mask_v = 2'b11;
        wr(`OFF_IRQ_MASK, 32'h00000003);
        for (int i = 0; i < 3; i++) i_agent.put_entry(i, `COND_ENABLED, 8'h07, `KEEP_SETTING);
        run(1'b0, `SENSOR1_HANDLE, 8'h03, `CODE_SUCCESS);
        chk({ev_en, en}, 32'h00490749);
        wr(`OFF_VIEW_SEL, 32'h0000000B);
        rd(`OFF_VIEW);
        chk(q[7:0], `COND_UNAVAILABLE);
        $display("test sensor_keep done");
        wr(`OFF_ALLOW, 32'h000000DF);
        for (int c = 0; c < 9; c++) begin
            for (int i = 0; i < 7; i++) i_agent.put_entry(i, `COND_DISABLED, 8'h01, 8'hFF);
            i_agent.put_entry(3'h7, c_t[c], s_t[c], v_t[c]);
            run(1'b0, h_t[c], n_t[c], x_t[c]);
            chk(code, x_t[c]);
            chk({ev_en, en}, 32'h00490749);
        end
        wr(`OFF_ALLOW, 32'h000000FF);
        $display("test rejects done");
        for (int i = 0; i < 8; i++) i_agent.put_entry(i, `COND_ENABLED, 7 - i, `KEEP_SETTING);
        run(1'b1, `ACTUATOR_HANDLE, 8'h08, `CODE_SUCCESS);
        chk(code, `CODE_SUCCESS);
        chk(act, 64'h0001020304050607);
        run(1'b1, `SENSOR0_HANDLE, 8'h08, `BAD_HANDLE_CODE);
        chk(code, `BAD_HANDLE_CODE);
        chk({act, ev_en, en}, {64'h0001020304050607, 32'h00490749});
        $display("test actuator done");
        end_of_test;
    end
endmodule // state_sensor_init_handler_test
